// file: oam_addr_unit.sv
// Operand addressing mode decoder and operand address former
`timescale 1ns/1ps
// Notes on behaviour
// - Seventeen addressing modes across inherent, immediate, direct, indexed, indirect, relative, bit.
// - Short forms address page zero, except short indexed forms, which reach 1FE; long forms reach all 64 Kbytes.
// - Long forms take more cycles than matching short forms; long direct and long indexed forms also take more bytes.
// - Memory-to-memory read-modify-write accepts only short forms; long ones are refused.
// - Inherent instructions are one byte; no operand bytes fetched.
// - Immediate instructions are two bytes; second byte is the operand value.
// - Short direct fetches one address byte; operand within 00 to FF.
// - Long direct fetches a two-byte address word, anywhere in 64 Kbytes.
// - Indexed address is unsigned sum of index register and offset.
// - Indexed without offset adds no byte with X, one prefix byte with Y.
// - Relative adds signed 8-bit displacement to next-instruction program counter.
// - Short indexed fetches one offset byte; addresses reach 00 to 1FE.
// - Short indirect reads a one-byte pointer, giving a page-zero address.
// - Indirect indexed adds index register to the pointer read from memory.
module oam_addr_unit (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [4:0] mode_i,
    input wire logic [7:0] prefix_i,
    input wire logic [7:0] opcode_i,
    input wire logic rmw_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] x_i,
    input wire logic [7:0] y_i,
    output logic pm_rd_o,
    output logic [15:0] pm_addr_o,
    input wire logic pm_valid_i,
    input wire logic [7:0] pm_data_i,
    output logic dm_rd_o,
    output logic [15:0] dm_addr_o,
    input wire logic dm_valid_i,
    input wire logic [7:0] dm_data_i,
    output logic busy_o,
    output logic done_o,
    output logic refuse_o,
    output logic [15:0] ea_o,
    output logic [15:0] target_o,
    output logic [7:0] imm_o,
    output logic [2:0] len_o,
    output logic [2:0] bit_pos_o
);

    // ****************************************************
    // Decode helpers
    // ****************************************************
    function automatic logic [1:0] op_bytes(input logic [4:0] m);
        unique case (m)
            oam_pkg::MODE_INH, oam_pkg::MODE_IDX_0: op_bytes = 2'd0;
            oam_pkg::MODE_DIR_L, oam_pkg::MODE_IDX_L: op_bytes = 2'd2;
            oam_pkg::MODE_BITREL_D, oam_pkg::MODE_BITREL_I: op_bytes = 2'd2;
            default: op_bytes = 2'd1;
        endcase
    endfunction

    function automatic logic [1:0] ptr_bytes(input logic [4:0] m);
        unique case (m)
            oam_pkg::MODE_IND_L, oam_pkg::MODE_IIDX_L: ptr_bytes = 2'd2;
            oam_pkg::MODE_IND_S, oam_pkg::MODE_IIDX_S, oam_pkg::MODE_REL_I,
            oam_pkg::MODE_BIT_I, oam_pkg::MODE_BITREL_I: ptr_bytes = 2'd1;
            default: ptr_bytes = 2'd0;
        endcase
    endfunction

    function automatic logic [15:0] rel_add(input logic [15:0] pc, input logic [7:0] d);
        rel_add = pc + {{8{d[7]}}, d};
    endfunction

    // ****************************************************
    // Request decode
    // ****************************************************
    wire logic has_prefix;
    wire logic use_y_w;
    wire logic is_long;
    wire logic illegal_w;
    wire logic [1:0] ops_w;
    wire logic [1:0] ptrs_w;
    wire logic [2:0] len_w;

    assign has_prefix = (prefix_i == oam_pkg::PFX_Y) || (prefix_i == oam_pkg::PFX_IND_Y)
                        || (prefix_i == oam_pkg::PFX_IND);
    assign use_y_w = (prefix_i == oam_pkg::PFX_Y) || (prefix_i == oam_pkg::PFX_IND_Y);
    assign is_long = (mode_i == oam_pkg::MODE_DIR_L) || (mode_i == oam_pkg::MODE_IDX_L)
                     || (mode_i == oam_pkg::MODE_IND_L) || (mode_i == oam_pkg::MODE_IIDX_L);
    assign illegal_w = (rmw_i && is_long) || (mode_i > oam_pkg::MODE_BITREL_I);
    assign ops_w = op_bytes(mode_i);
    assign ptrs_w = ptr_bytes(mode_i);
    assign len_w = 3'd1 + {2'b00, has_prefix} + {1'b0, ops_w};

    // ****************************************************
    // State and captured bytes
    // ****************************************************
    oam_pkg::oam_state_t state_reg, state_next;
    logic [4:0] mode_reg;
    logic [7:0] idx_reg;
    logic [15:0] pc_reg;
    logic [1:0] ops_reg, ptrs_reg, cnt_reg;
    logic [7:0] b0_reg, b1_reg, p0_reg, p1_reg;
    logic pm_rd_reg, dm_rd_reg, done_reg, refuse_reg;
    logic [15:0] pm_addr_reg, dm_addr_reg, ea_reg, target_reg;
    logic [7:0] imm_reg;
    logic [2:0] len_reg, bit_pos_reg;

    wire logic fetch_last;
    wire logic ptr_last;
    wire logic [15:0] pc_after;
    wire logic [7:0] ptr_addr;

    assign fetch_last = pm_rd_reg && pm_valid_i && (cnt_reg == ops_reg - 2'd1);
    assign ptr_last = dm_rd_reg && dm_valid_i && (cnt_reg == ptrs_reg - 2'd1);
    assign pc_after = pc_reg + {14'h0000, ops_reg};
    assign ptr_addr = (state_reg == oam_pkg::ST_FETCH && fetch_last && cnt_reg == 2'd0)
                      ? pm_data_i : b0_reg;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            oam_pkg::ST_IDLE:
                if (start_i && !illegal_w)
                    state_next = (ops_w != 2'd0) ? oam_pkg::ST_FETCH : oam_pkg::ST_CALC;
            oam_pkg::ST_FETCH:
                if (fetch_last)
                    state_next = (ptrs_reg != 2'd0) ? oam_pkg::ST_PTR : oam_pkg::ST_CALC;
            oam_pkg::ST_PTR:
                if (ptr_last)
                    state_next = oam_pkg::ST_CALC;
            oam_pkg::ST_CALC:
                state_next = oam_pkg::ST_IDLE;
        endcase
    end

    // ****************************************************
    // Effective address forming
    // ****************************************************
    logic [15:0] ea_w, target_w;
    always_comb
    begin
        target_w = pc_after;
        unique case (mode_reg)
            oam_pkg::MODE_DIR_S, oam_pkg::MODE_BIT_D: ea_w = {oam_pkg::PAGE_ZERO_HI, b0_reg};
            oam_pkg::MODE_DIR_L: ea_w = {b0_reg, b1_reg};
            oam_pkg::MODE_IDX_0: ea_w = {oam_pkg::PAGE_ZERO_HI, idx_reg};
            oam_pkg::MODE_IDX_S: ea_w = {7'h00, {1'b0, b0_reg} + {1'b0, idx_reg}};
            oam_pkg::MODE_IDX_L: ea_w = {b0_reg, b1_reg} + {8'h00, idx_reg};
            oam_pkg::MODE_IND_S, oam_pkg::MODE_BIT_I: ea_w = {oam_pkg::PAGE_ZERO_HI, p0_reg};
            oam_pkg::MODE_IND_L: ea_w = {p0_reg, p1_reg};
            oam_pkg::MODE_IIDX_S: ea_w = {7'h00, {1'b0, p0_reg} + {1'b0, idx_reg}};
            oam_pkg::MODE_IIDX_L: ea_w = {p0_reg, p1_reg} + {8'h00, idx_reg};
            oam_pkg::MODE_REL_D:
            begin
                ea_w = rel_add(pc_after, b0_reg);
                target_w = ea_w;
            end
            oam_pkg::MODE_REL_I:
            begin
                ea_w = rel_add(pc_after, p0_reg);
                target_w = ea_w;
            end
            oam_pkg::MODE_BITREL_D:
            begin
                ea_w = {oam_pkg::PAGE_ZERO_HI, b0_reg};
                target_w = rel_add(pc_after, b1_reg);
            end
            oam_pkg::MODE_BITREL_I:
            begin
                ea_w = {oam_pkg::PAGE_ZERO_HI, p0_reg};
                target_w = rel_add(pc_after, b1_reg);
            end
            default: ea_w = oam_pkg::EA_RESET;
        endcase
    end

    // ****************************************************
    // Registers
    // ****************************************************
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= oam_pkg::ST_IDLE;
            mode_reg <= 5'h00;
            idx_reg <= oam_pkg::BYTE_RESET;
            pc_reg <= oam_pkg::EA_RESET;
            ops_reg <= 2'd0;
            ptrs_reg <= 2'd0;
            len_reg <= oam_pkg::LEN_RESET;
            bit_pos_reg <= 3'd0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == oam_pkg::ST_IDLE && start_i && !illegal_w)
            begin
                mode_reg <= mode_i;
                idx_reg <= use_y_w ? y_i : x_i;
                pc_reg <= pc_i;
                ops_reg <= ops_w;
                ptrs_reg <= ptrs_w;
                len_reg <= len_w;
                bit_pos_reg <= opcode_i[oam_pkg::BIT_POS_LSB +: 3];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_reg <= 2'd0;
            b0_reg <= oam_pkg::BYTE_RESET;
            b1_reg <= oam_pkg::BYTE_RESET;
            p0_reg <= oam_pkg::BYTE_RESET;
            p1_reg <= oam_pkg::BYTE_RESET;
        end
        else
        begin
            if (state_next != state_reg)
                cnt_reg <= 2'd0;
            else if ((pm_rd_reg && pm_valid_i) || (dm_rd_reg && dm_valid_i))
                cnt_reg <= cnt_reg + 2'd1;
            if (pm_rd_reg && pm_valid_i && cnt_reg == 2'd0)
                b0_reg <= pm_data_i;
            if (pm_rd_reg && pm_valid_i && cnt_reg == 2'd1)
                b1_reg <= pm_data_i;
            if (dm_rd_reg && dm_valid_i && cnt_reg == 2'd0)
                p0_reg <= dm_data_i;
            if (dm_rd_reg && dm_valid_i && cnt_reg == 2'd1)
                p1_reg <= dm_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pm_rd_reg <= 1'b0;
            pm_addr_reg <= oam_pkg::EA_RESET;
            dm_rd_reg <= 1'b0;
            dm_addr_reg <= oam_pkg::EA_RESET;
        end
        else
        begin
            pm_rd_reg <= (state_next == oam_pkg::ST_FETCH) && !fetch_last;
            if (state_reg == oam_pkg::ST_IDLE)
                pm_addr_reg <= pc_i;
            else if (pm_rd_reg && pm_valid_i)
                pm_addr_reg <= pm_addr_reg + 16'h0001;
            dm_rd_reg <= (state_next == oam_pkg::ST_PTR) && !ptr_last;
            if (state_reg == oam_pkg::ST_FETCH)
                dm_addr_reg <= {oam_pkg::PAGE_ZERO_HI, ptr_addr};
            else if (dm_rd_reg && dm_valid_i)
                dm_addr_reg <= dm_addr_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            done_reg <= 1'b0;
            refuse_reg <= 1'b0;
            ea_reg <= oam_pkg::EA_RESET;
            target_reg <= oam_pkg::EA_RESET;
            imm_reg <= oam_pkg::BYTE_RESET;
        end
        else
        begin
            done_reg <= (state_reg == oam_pkg::ST_CALC);
            refuse_reg <= (state_reg == oam_pkg::ST_IDLE) && start_i && illegal_w;
            if (state_reg == oam_pkg::ST_CALC)
            begin
                ea_reg <= ea_w;
                target_reg <= target_w;
                imm_reg <= b0_reg;
            end
        end
    end

    assign pm_rd_o = pm_rd_reg;
    assign pm_addr_o = pm_addr_reg;
    assign dm_rd_o = dm_rd_reg;
    assign dm_addr_o = dm_addr_reg;
    assign busy_o = (state_reg != oam_pkg::ST_IDLE);
    assign done_o = done_reg;
    assign refuse_o = refuse_reg;
    assign ea_o = ea_reg;
    assign target_o = target_reg;
    assign imm_o = imm_reg;
    assign len_o = len_reg;
    assign bit_pos_o = bit_pos_reg;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_inh_start;
        state_reg == oam_pkg::ST_IDLE && start_i && !illegal_w && ops_w == 2'd0;
    endsequence

    a_inh_no_fetch: assert property (s_inh_start |-> !pm_rd_o [*2] ##1 done_o)
        else $error("zero-operand mode fetched program bytes");
    a_rmw_long_refused: assert property (state_reg == oam_pkg::ST_IDLE && start_i && rmw_i
        && is_long |=> refuse_o && !busy_o)
        else $error("long form accepted for read-modify-write");
    a_long_longer: assert property (start_i && (mode_i == oam_pkg::MODE_DIR_L
        || mode_i == oam_pkg::MODE_IDX_L) |-> ops_w == 2'd2)
        else $error("long form not two operand bytes");
    a_short_dir_page: assert property (done_o && mode_reg == oam_pkg::MODE_DIR_S
        |-> ea_o[15:8] == 8'h00 && ea_o[7:0] == b0_reg)
        else $error("short direct left page zero");
    a_idx_short_range: assert property (done_o && mode_reg == oam_pkg::MODE_IDX_S
        |-> ea_o == {8'h00, b0_reg} + {8'h00, idx_reg})
        else $error("short indexed sum wrong");
    a_rel_target: assert property (done_o && mode_reg == oam_pkg::MODE_REL_D
        |-> target_o == pc_reg + 16'h0001 + {{8{b0_reg[7]}}, b0_reg})
        else $error("relative target wrong");
    a_len_counted: assert property (state_reg == oam_pkg::ST_IDLE && start_i && !illegal_w
        |=> len_o == 3'd1 + {2'b00, $past(has_prefix)} + {1'b0, ops_reg})
        else $error("instruction length wrong");
    a_ptr_after_fetch: assert property (dm_rd_o |-> !pm_rd_o && state_reg == oam_pkg::ST_PTR)
        else $error("pointer read overlaps operand fetch");
    a_imm_value: assert property (done_o && mode_reg == oam_pkg::MODE_IMM
        |-> imm_o == b0_reg)
        else $error("immediate byte lost");

endmodule

// file: oam_addr_unit_test.sv
// Self-checking testbench for the operand addressing unit
`timescale 1ns/1ps
module oam_addr_unit_test;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic [4:0] mode = 5'h00;
    logic [7:0] prefix = 8'h00;
    logic [7:0] opcode = 8'h00;
    logic rmw = 1'b0;
    logic [15:0] pc = 16'h0000;
    logic [7:0] x = 8'h00;
    logic [7:0] y = 8'h00;
    logic pm_rd, pm_valid, dm_rd, dm_valid, busy, done, refuse;
    logic [15:0] pm_addr, dm_addr, ea, target;
    logic [7:0] pm_data, dm_data, imm;
    logic [2:0] len, bit_pos;
    int error_cnt = 0;
    int checked = 0;
    int cyc, npm, ndm, cs;
    logic got_done, got_ref;
    int ops_tab [17] = '{0, 1, 1, 2, 0, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2};

    oam_addr_unit oam_addr_unit_inst (
        .clock_i(clock),
        .rst_b_i(rst_b),
        .start_i(start),
        .mode_i(mode),
        .prefix_i(prefix),
        .opcode_i(opcode),
        .rmw_i(rmw),
        .pc_i(pc),
        .x_i(x),
        .y_i(y),
        .pm_rd_o(pm_rd),
        .pm_addr_o(pm_addr),
        .pm_valid_i(pm_valid),
        .pm_data_i(pm_data),
        .dm_rd_o(dm_rd),
        .dm_addr_o(dm_addr),
        .dm_valid_i(dm_valid),
        .dm_data_i(dm_data),
        .busy_o(busy),
        .done_o(done),
        .refuse_o(refuse),
        .ea_o(ea),
        .target_o(target),
        .imm_o(imm),
        .len_o(len),
        .bit_pos_o(bit_pos)
    );

    oam_mem_model oam_mem_model_inst (
        .clock_i(clock),
        .rst_b_i(rst_b),
        .pm_rd_i(pm_rd),
        .pm_addr_i(pm_addr),
        .pm_valid_o(pm_valid),
        .pm_data_o(pm_data),
        .dm_rd_i(dm_rd),
        .dm_addr_i(dm_addr),
        .dm_valid_o(dm_valid),
        .dm_data_o(dm_data)
    );

    initial
    begin
        forever #20 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (pm_rd === 1'b1 && pm_valid === 1'b1)
            npm++;
        if (dm_rd === 1'b1 && dm_valid === 1'b1)
            ndm++;
    end

    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (exp !== got)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic run_op(input logic [4:0] m, input logic [7:0] pf, input logic [7:0] op,
                          input logic rw, input logic [15:0] p);
        @(negedge clock);
        mode = m;
        prefix = pf;
        opcode = op;
        rmw = rw;
        pc = p;
        start = 1'b1;
        npm = 0;
        ndm = 0;
        cyc = 0;
        got_done = 1'b0;
        got_ref = 1'b0;
        @(negedge clock);
        got_ref = (refuse === 1'b1);
        start = 1'b0;
        while (!got_done && !got_ref && cyc < 60)
        begin
            @(posedge clock);
            #1;
            cyc++;
            got_done = (done === 1'b1);
            got_ref = (refuse === 1'b1);
        end
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_lengths();
        for (int i = 0; i < 17; i++)
        begin
            run_op(5'(i), 8'h00, 8'h02, 1'b0, 16'h0010);
            chk("done", 16'h1, 16'(got_done));
            chk("len", 16'(1 + ops_tab[i]), 16'(len));
            chk("reads", 16'(ops_tab[i]), 16'(npm));
        end
        run_op(oam_pkg::MODE_INH, 8'h00, 8'h9d, 1'b0, 16'h0010);
        chk("inh_cycles", 16'h1, 16'(cyc));
        $display("test lengths done");
    endtask

    task automatic t_direct();
        oam_mem_model_inst.pmem[8'h20] = 8'h9c;
        oam_mem_model_inst.pmem[8'h30] = 8'h12;
        oam_mem_model_inst.pmem[8'h31] = 8'h34;
        run_op(oam_pkg::MODE_IMM, 8'h00, 8'ha6, 1'b0, 16'h0020);
        chk("imm", 16'h009c, 16'(imm));
        run_op(oam_pkg::MODE_DIR_S, 8'h00, 8'hb6, 1'b0, 16'h0020);
        chk("ea_short", 16'h009c, ea);
        cs = cyc;
        run_op(oam_pkg::MODE_DIR_L, 8'h00, 8'hc6, 1'b0, 16'h0030);
        chk("ea_long", 16'h1234, ea);
        chk("long_slower", 16'h1, 16'(cyc > cs));
        $display("test direct done");
    endtask

    task automatic t_index();
        x = 8'hff;
        y = 8'h33;
        oam_mem_model_inst.pmem[8'h40] = 8'hff;
        run_op(oam_pkg::MODE_IDX_0, 8'h00, 8'hf6, 1'b0, 16'h0040);
        chk("idx_x", 16'h00ff, ea);
        chk("len_x", 16'h1, 16'(len));
        run_op(oam_pkg::MODE_IDX_0, 8'h90, 8'hf6, 1'b0, 16'h0040);
        chk("idx_y", 16'h0033, ea);
        chk("len_y", 16'h2, 16'(len));
        run_op(oam_pkg::MODE_IDX_S, 8'h00, 8'he6, 1'b0, 16'h0040);
        chk("idx_short", 16'h01fe, ea);
        $display("test indexed done");
    endtask

    task automatic t_indirect();
        oam_mem_model_inst.wait_n = 2;
        y = 8'h80;
        oam_mem_model_inst.pmem[8'h60] = 8'h70;
        oam_mem_model_inst.dmem[8'h70] = 8'hc4;
        run_op(oam_pkg::MODE_IND_S, 8'h92, 8'hb6, 1'b0, 16'h0060);
        chk("ind_ea", 16'h00c4, ea);
        chk("ind_len", 16'h3, 16'(len));
        chk("ind_ptr_reads", 16'h1, 16'(ndm));
        run_op(oam_pkg::MODE_IIDX_S, 8'h91, 8'he6, 1'b0, 16'h0060);
        chk("iidx_ea", 16'h0144, ea);
        oam_mem_model_inst.wait_n = 0;
        $display("test indirect done");
    endtask

    task automatic t_relative();
        oam_mem_model_inst.pmem[8'h80] = 8'h80;
        oam_mem_model_inst.pmem[8'h90] = 8'h7f;
        run_op(oam_pkg::MODE_REL_D, 8'h00, 8'h26, 1'b0, 16'h0080);
        chk("rel_back", 16'h0001, target);
        run_op(oam_pkg::MODE_REL_D, 8'h00, 8'h26, 1'b0, 16'h0090);
        chk("rel_fwd", 16'h0110, target);
        $display("test relative done");
    endtask

    task automatic t_bits();
        oam_mem_model_inst.pmem[8'ha0] = 8'h3c;
        for (int i = 0; i < 8; i++)
        begin
            run_op(oam_pkg::MODE_BIT_D, 8'h00, {4'h1, 3'(i), 1'b0}, 1'b1, 16'h00a0);
            chk("bit_pos", 16'(i), 16'(bit_pos));
            chk("bit_ea", 16'h003c, ea);
        end
        oam_mem_model_inst.pmem[8'hb0] = 8'h50;
        oam_mem_model_inst.pmem[8'hb1] = 8'h10;
        run_op(oam_pkg::MODE_BITREL_I, 8'h92, 8'h00, 1'b0, 16'h00b0);
        chk("bitrel_ea", 16'h00f5, ea);
        chk("bitrel_target", 16'h00c2, target);
        $display("test bits done");
    endtask

    task automatic t_refuse();
        run_op(oam_pkg::MODE_DIR_L, 8'h00, 8'hc3, 1'b1, 16'h0030);
        chk("rmw_long_ref", 16'h1, 16'(got_ref));
        chk("rmw_long_reads", 16'h0, 16'(npm));
        chk("rmw_long_busy", 16'h0, 16'(busy));
        run_op(5'h11, 8'h00, 8'h00, 1'b0, 16'h0030);
        chk("bad_mode_ref", 16'h1, 16'(got_ref));
        $display("test refuse done");
    endtask

    initial
    begin
        #(40 * 20000);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        t_lengths();
        t_direct();
        t_index();
        t_indirect();
        t_relative();
        t_bits();
        t_refuse();
        report_and_stop();
    end
endmodule

// file: oam_mem_model.sv
// Program and data memory model answering the unit's read requests
`timescale 1ns/1ps
module oam_mem_model (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic pm_rd_i,
    input wire logic [15:0] pm_addr_i,
    output logic pm_valid_o,
    output logic [7:0] pm_data_o,
    input wire logic dm_rd_i,
    input wire logic [15:0] dm_addr_i,
    output logic dm_valid_o,
    output logic [7:0] dm_data_o
);
    logic [7:0] pmem [0:255];
    logic [7:0] dmem [0:255];
    int wait_n = 0;
    logic [3:0] pcnt_reg;
    logic [3:0] dcnt_reg;

    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            pmem[i] = 8'(i) ^ 8'h5a;
            dmem[i] = 8'(i) ^ 8'ha5;
        end
    end

    // Wait states before each answer
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pcnt_reg <= 4'h0;
            dcnt_reg <= 4'h0;
        end
        else
        begin
            pcnt_reg <= (pm_rd_i && !pm_valid_o) ? pcnt_reg + 4'h1 : 4'h0;
            dcnt_reg <= (dm_rd_i && !dm_valid_o) ? dcnt_reg + 4'h1 : 4'h0;
        end
    end

    // Data lines carry the inverted byte outside an answer
    assign pm_valid_o = pm_rd_i && (int'(pcnt_reg) >= wait_n);
    assign pm_data_o = pm_valid_o ? pmem[pm_addr_i[7:0]] : ~pmem[pm_addr_i[7:0]];
    assign dm_valid_o = dm_rd_i && (int'(dcnt_reg) >= wait_n);
    assign dm_data_o = dm_valid_o ? dmem[dm_addr_i[7:0]] : ~dmem[dm_addr_i[7:0]];
endmodule

// file: oam_pkg.sv
// Constants and types for the operand addressing unit
package oam_pkg;

    // ****************************************************
    // Addressing modes, seventeen in all
    // ****************************************************
    typedef enum logic [4:0] {
        MODE_INH      = 5'h00,
        MODE_IMM      = 5'h01,
        MODE_DIR_S    = 5'h02,
        MODE_DIR_L    = 5'h03,
        MODE_IDX_0    = 5'h04,
        MODE_IDX_S    = 5'h05,
        MODE_IDX_L    = 5'h06,
        MODE_IND_S    = 5'h07,
        MODE_IND_L    = 5'h08,
        MODE_IIDX_S   = 5'h09,
        MODE_IIDX_L   = 5'h0a,
        MODE_REL_D    = 5'h0b,
        MODE_REL_I    = 5'h0c,
        MODE_BIT_D    = 5'h0d,
        MODE_BIT_I    = 5'h0e,
        MODE_BITREL_D = 5'h0f,
        MODE_BITREL_I = 5'h10
    } oam_mode_t;

    // ****************************************************
    // Sequencer states
    // ****************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_PTR   = 2'b10,
        ST_CALC  = 2'b11
    } oam_state_t;

    // ****************************************************
    // Prefix bytes, page zero and bit field
    // ****************************************************
    localparam logic [7:0] PFX_Y = 8'h90;
    localparam logic [7:0] PFX_IND_Y = 8'h91;
    localparam logic [7:0] PFX_IND = 8'h92;
    localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
    localparam int BIT_POS_LSB = 1;
    localparam logic [15:0] EA_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] LEN_RESET = 3'h0;

endpackage
